//--- acs_regs.vh
// Register map, field positions, reset values and timing counts of the ADC sequencer.
// Assumes an AXI4-Lite master with 32-bit data and one word per register.
// Functional notes
// R01: After reset only a communications register write is accepted before other transfers; the code also accepts communications register reads at any time.
// R02: Communications write selects channel, next direction, power-down and next register.
// R03: Host writes communications register before every other register access.
// R04: Hold bit set keeps filter and modulator reset; no conversion or calibration.
// R05: Hold clear in normal mode converts continuously, one result per data period.
// R06: Normal mode: ready goes low three data periods after hold clears.
// R07: Ready returns high once a data register read completes.
// R08: Unread result at next result: ready high 500 clocks, then low again.
// R09: Hold set while ready low keeps ready low until read or restart.
// R10: Data register may be reread while the next conversion runs.
// R11: Communications status bit mirrors ready output, zero when result valid.
// R12: Mode bits: 00 normal, 01 self, 10 zero-scale, 11 full-scale calibration.
// R13: Self calibration does zero then full step; mode clears after six periods.
// R14: Self calibration: ready low nine periods plus pipeline delay after start.
// R15: System calibration: mode clears after three periods; ready after four plus delay.
// R16: Pipeline delay before first result after calibration is 2000 clocks.
// R17: Host sets hold before writing a calibration command while free-running.
// R18: Each channel keeps its own offset and gain pair, written by calibration.
// R19: Self calibration shorts selected channel inputs for its zero-scale step.
// R20: Host configures gain, polarity, buffer and channel before self calibration.
// R21: Host should recalibrate after gain, polarity, buffer or rate changes.
// R22: Calibration command with ready low raises ready within 128 clocks.
// R23: Data period is 128 times decimation rate clocks, doubled with divider.
// R24: Sequencer is a hold, calibrate, settle and convert state machine.
// R25: After any calibration the block converts freely with mode bits 00.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_IDX_COMM     3'h0
`define ACS_IDX_SETUP    3'h1
`define ACS_IDX_CLOCK    3'h2
`define ACS_IDX_DATA     3'h3
`define ACS_IDX_OFS0     3'h4
`define ACS_IDX_OFS1     3'h5
`define ACS_IDX_GAIN0    3'h6
`define ACS_IDX_GAIN1    3'h7
`define ACS_COMM_CH      0
`define ACS_COMM_PD      2
`define ACS_COMM_RD      3
`define ACS_COMM_TGT     6:4
`define ACS_COMM_RDY     7
`define ACS_SET_HOLD     0
`define ACS_SET_MODE     7:6
`define ACS_CLK_SEL      2:0
`define ACS_CLK_DIV      3
`define ACS_SETUP_RST    8'h01
`define ACS_CLOCK_RST    4'h5
`define ACS_MODE_NORM    2'h0
`define ACS_MODE_SELF    2'h1
`define ACS_MODE_ZERO    2'h2
`define ACS_MODE_FULL    2'h3
`define ACS_MOD_SHIFT    7
`define ACS_PIPE_CYCLES  2000
`define ACS_BLIP_CYCLES  500
`define ACS_N_NORM       4'h3
`define ACS_N_SELF       4'h6
`define ACS_N_SELF_HALF  4'h3
`define ACS_N_SYS        4'h3
`define ACS_N_SELF_POST  4'h3
`define ACS_N_SYS_POST   4'h1
`define ACS_N_FREE       4'h1
`define ACS_DEC_0        9'h187
`define ACS_DEC_1        9'h139
`define ACS_DEC_2        9'h04E
`define ACS_DEC_3        9'h027
`define ACS_DEC_4        9'h180
`define ACS_DEC_5        9'h140
`define ACS_DEC_6        9'h04D
`define ACS_DEC_7        9'h026
`define ACS_RESP_OKAY    2'h0
`define ACS_RESP_SLVERR  2'h2
`endif

//--- acs_sequencer.v
// Conversion and calibration sequencer of a two-channel sigma-delta ADC with AXI4-Lite registers.
// Assumes the filter supplies a sample and coefficients, and all inputs except the asynchronous SYS_RST are synchronous to CLK.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_sequencer #(
  parameter AW         = 8,
  parameter PIPE_CYC   = `ACS_PIPE_CYCLES,
  parameter BLIP_CYC   = `ACS_BLIP_CYCLES
) (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire [AW-1:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [AW-1:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire [15:0] SAMPLE_IN,
  input  wire [23:0] CAL_OFFSET_IN,
  input  wire [23:0] CAL_GAIN_IN,
  output wire        RESULT_READY_N,
  output wire        FILTER_RESET,
  output wire        SHORT_INPUTS,
  output wire        CHANNEL,
  output wire        POWER_DOWN
);
  localparam [1:0] ST_HOLD = 2'h0;
  localparam [1:0] ST_CAL  = 2'h1;
  localparam [1:0] ST_SETL = 2'h2;
  localparam [1:0] ST_CONV = 2'h3;

  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rdata_reg;
  reg [7:0]  comm_reg;
  reg [7:0]  setup_reg;
  reg [3:0]  clock_reg;
  reg        armed_reg;
  reg [15:0] data_reg;
  reg        ready_n_reg;
  reg [9:0]  blip_reg;
  reg [1:0]  state_reg;
  reg [16:0] tick_reg;
  reg [3:0]  per_reg;
  reg [3:0]  target_reg;
  reg        pipe_reg;
  reg [11:0] settle_reg;
  reg        hold_q_reg;
  reg        restart_reg;
  reg        cal_ch_reg;
  reg        wr_ofs_reg;
  reg        wr_gain_reg;
  reg        filt_rst_reg;
  reg [23:0] ofs_reg  [0:1];
  reg [23:0] gain_reg [0:1];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  function [8:0] decim;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: decim = `ACS_DEC_0;
        3'h1: decim = `ACS_DEC_1;
        3'h2: decim = `ACS_DEC_2;
        3'h3: decim = `ACS_DEC_3;
        3'h4: decim = `ACS_DEC_4;
        3'h5: decim = `ACS_DEC_5;
        3'h6: decim = `ACS_DEC_6;
        default: decim = `ACS_DEC_7;
      endcase
    end
  endfunction

  // Write channels are taken together, one transfer at a time.
  wire        wr_go  = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_reg;
  wire        rd_go  = S_AXI_ARVALID & ~rvalid_reg;
  wire [2:0]  widx   = S_AXI_AWADDR[4:2];
  wire [2:0]  ridx   = S_AXI_ARADDR[4:2];
  wire        w_map  = (S_AXI_AWADDR[AW-1:5] == {(AW-5){1'b0}});
  wire        r_map  = (S_AXI_ARADDR[AW-1:5] == {(AW-5){1'b0}});
  wire [2:0]  tgt    = comm_reg[`ACS_COMM_TGT];
  wire        w_ok   = w_map & ((widx == `ACS_IDX_COMM) |
                       (armed_reg & ~comm_reg[`ACS_COMM_RD] & (widx == tgt))); // R01
  wire        r_ok   = r_map & ((ridx == `ACS_IDX_COMM) |
                       (armed_reg & comm_reg[`ACS_COMM_RD] & (ridx == tgt))); // R03
  wire        wr_en  = wr_go & w_ok;
  wire [31:0] wmerge_setup = merge({24'h000000, setup_reg}, S_AXI_WDATA, S_AXI_WSTRB);
  wire [31:0] wmerge_comm  = merge({24'h000000, comm_reg}, S_AXI_WDATA, S_AXI_WSTRB);
  wire [31:0] wmerge_clock = merge({28'h0000000, clock_reg}, S_AXI_WDATA, S_AXI_WSTRB);
  wire        setup_wr = wr_en & (widx == `ACS_IDX_SETUP);
  wire        data_rd  = rd_go & r_ok & (ridx == `ACS_IDX_DATA);
  wire        hold     = setup_reg[`ACS_SET_HOLD];
  wire [1:0]  mode     = setup_reg[`ACS_SET_MODE];
  wire [16:0] odr_len  = {8'h00, decim(clock_reg[`ACS_CLK_SEL])}
                         << (`ACS_MOD_SHIFT + clock_reg[`ACS_CLK_DIV]); // R23
  wire        per_end  = (tick_reg == odr_len - 17'h00001);
  wire [3:0]  per_next = per_reg + 4'h1;
  wire        start    = restart_reg | (hold_q_reg & ~hold);
  wire        unread   = ~ready_n_reg & ~data_rd;

  assign S_AXI_AWREADY  = wr_go;
  assign S_AXI_WREADY   = wr_go;
  assign S_AXI_BVALID   = bvalid_reg;
  assign S_AXI_BRESP    = bresp_reg;
  assign S_AXI_ARREADY  = rd_go;
  assign S_AXI_RVALID   = rvalid_reg;
  assign S_AXI_RRESP    = rresp_reg;
  assign S_AXI_RDATA    = rdata_reg;
  assign RESULT_READY_N = ready_n_reg;
  assign FILTER_RESET   = filt_rst_reg;
  assign SHORT_INPUTS   = (state_reg == ST_CAL) & (mode == `ACS_MODE_SELF) &
                          (per_reg < `ACS_N_SELF_HALF); // R19
  assign CHANNEL        = comm_reg[`ACS_COMM_CH];
  assign POWER_DOWN     = comm_reg[`ACS_COMM_PD];

  // Bus responses and register reads.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `ACS_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= `ACS_RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= r_map ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
        rdata_reg  <= 32'h00000000;
        if (r_ok) begin
          case (ridx)
            `ACS_IDX_COMM:  rdata_reg <= {24'h000000, ready_n_reg, comm_reg[6:0]}; // R11
            `ACS_IDX_SETUP: rdata_reg <= {24'h000000, setup_reg};
            `ACS_IDX_CLOCK: rdata_reg <= {28'h0000000, clock_reg};
            `ACS_IDX_DATA:  rdata_reg <= {16'h0000, data_reg}; // R10
            `ACS_IDX_OFS0:  rdata_reg <= {8'h00, ofs_reg[0]};
            `ACS_IDX_OFS1:  rdata_reg <= {8'h00, ofs_reg[1]};
            `ACS_IDX_GAIN0: rdata_reg <= {8'h00, gain_reg[0]};
            default:        rdata_reg <= {8'h00, gain_reg[1]};
          endcase
        end
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Per-channel coefficient pairs; a calibration result wins over a host write.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_coef
      wire [31:0] ofs_wr  = merge({8'h00, ofs_reg[ch]}, S_AXI_WDATA, S_AXI_WSTRB);
      wire [31:0] gain_wr = merge({8'h00, gain_reg[ch]}, S_AXI_WDATA, S_AXI_WSTRB);
      always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          ofs_reg[ch]  <= 24'h000000;
          gain_reg[ch] <= 24'h000000;
        end else begin
          if (wr_en && widx == `ACS_IDX_OFS0 + ch)
            ofs_reg[ch] <= ofs_wr[23:0];
          if (wr_en && widx == `ACS_IDX_GAIN0 + ch)
            gain_reg[ch] <= gain_wr[23:0];
          if (wr_ofs_reg && cal_ch_reg == ch)
            ofs_reg[ch] <= CAL_OFFSET_IN; // R18
          if (wr_gain_reg && cal_ch_reg == ch)
            gain_reg[ch] <= CAL_GAIN_IN; // R18
        end
      end
    end
  endgenerate

  // Access order, configuration and the conversion sequence.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      comm_reg     <= 8'h00;
      setup_reg    <= `ACS_SETUP_RST;
      clock_reg    <= `ACS_CLOCK_RST;
      armed_reg    <= 1'b0;
      data_reg     <= 16'h0000;
      ready_n_reg  <= 1'b1;
      blip_reg     <= 10'h000;
      state_reg    <= ST_HOLD;
      tick_reg     <= 17'h00000;
      per_reg      <= 4'h0;
      target_reg   <= 4'h0;
      pipe_reg     <= 1'b0;
      settle_reg   <= 12'h000;
      hold_q_reg   <= 1'b1;
      restart_reg  <= 1'b0;
      cal_ch_reg   <= 1'b0;
      wr_ofs_reg   <= 1'b0;
      wr_gain_reg  <= 1'b0;
      filt_rst_reg <= 1'b1;
    end else begin
      wr_ofs_reg   <= 1'b0;
      wr_gain_reg  <= 1'b0;
      restart_reg  <= 1'b0;
      hold_q_reg   <= hold;
      filt_rst_reg <= hold; // R04
      if ((wr_go && w_map && widx != `ACS_IDX_COMM) || (rd_go && r_map && ridx != `ACS_IDX_COMM))
        armed_reg <= 1'b0; // R01
      if (wr_en && widx == `ACS_IDX_COMM) begin
        comm_reg  <= {1'b0, wmerge_comm[6:0]}; // R02
        armed_reg <= 1'b1;
      end
      if (wr_en && widx == `ACS_IDX_CLOCK)
        clock_reg <= wmerge_clock[3:0];
      if (setup_wr) begin
        setup_reg <= wmerge_setup[7:0];
        if (!hold && !wmerge_setup[`ACS_SET_HOLD] &&
            wmerge_setup[`ACS_SET_MODE] != `ACS_MODE_NORM)
          restart_reg <= 1'b1; // R14
      end
      if (data_rd) begin
        ready_n_reg <= 1'b1; // R07
        blip_reg    <= 10'h000;
      end else if (blip_reg != 10'h000) begin
        blip_reg <= blip_reg - 10'h001;
        if (blip_reg == 10'h001)
          ready_n_reg <= 1'b0; // R08
      end
      tick_reg <= per_end ? 17'h00000 : tick_reg + 17'h00001;
      if (per_end)
        per_reg <= per_next;
      if (hold) begin
        state_reg <= ST_HOLD; // R04 R09
        tick_reg  <= 17'h00000;
        per_reg   <= 4'h0;
      end else if (start) begin
        ready_n_reg <= 1'b1; // R22
        blip_reg    <= 10'h000;
        tick_reg    <= 17'h00000;
        per_reg     <= 4'h0;
        cal_ch_reg  <= comm_reg[`ACS_COMM_CH];
        pipe_reg    <= 1'b0;
        if (mode == `ACS_MODE_NORM) begin
          state_reg  <= ST_CONV;
          target_reg <= `ACS_N_NORM; // R06
        end else begin
          state_reg  <= ST_CAL; // R12
          target_reg <= (mode == `ACS_MODE_SELF) ? `ACS_N_SELF : `ACS_N_SYS;
        end
      end else begin
        case (state_reg) // R24
          ST_CAL: begin
            if (per_end && mode == `ACS_MODE_SELF && per_next == `ACS_N_SELF_HALF)
              wr_ofs_reg <= 1'b1; // R13
            if (per_end && per_next == target_reg) begin
              wr_ofs_reg  <= (mode == `ACS_MODE_ZERO);
              wr_gain_reg <= (mode != `ACS_MODE_ZERO);
              setup_reg[`ACS_SET_MODE] <= `ACS_MODE_NORM; // R13 R15 R25
              state_reg   <= ST_CONV;
              per_reg     <= 4'h0;
              pipe_reg    <= 1'b1;
              target_reg  <= (mode == `ACS_MODE_SELF) ? `ACS_N_SELF_POST : `ACS_N_SYS_POST;
            end
          end
          ST_CONV: begin
            if (per_end && per_next == target_reg) begin
              per_reg    <= 4'h0;
              target_reg <= `ACS_N_FREE; // R05
              if (pipe_reg) begin
                state_reg  <= ST_SETL;
                settle_reg <= 12'h000;
              end else begin
                data_reg <= SAMPLE_IN;
                if (unread) begin
                  ready_n_reg <= 1'b1; // R08
                  blip_reg    <= BLIP_CYC[9:0];
                end else begin
                  ready_n_reg <= 1'b0; // R05
                end
              end
            end
          end
          ST_SETL: begin
            settle_reg <= settle_reg + 12'h001;
            tick_reg   <= 17'h00000;
            per_reg    <= 4'h0;
            if (settle_reg == PIPE_CYC[11:0] - 12'h001) begin
              state_reg   <= ST_CONV; // R16
              pipe_reg    <= 1'b0;
              data_reg    <= SAMPLE_IN;
              ready_n_reg <= 1'b0; // R14 R15
            end
          end
          default: begin
            state_reg <= ST_HOLD;
          end
        endcase
      end
    end
  end
endmodule

//--- acs_sequencer_chk.sv
// Checker of the ADC sequencer, bound to the ports of its top module.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module acs_sequencer_chk #(
  parameter AW       = 8,
  parameter BLIP_CYC = 500
) (
  input wire          CLK,
  input wire          SYS_RST,
  input wire [AW-1:0] S_AXI_AWADDR,
  input wire          S_AXI_AWVALID,
  input wire          S_AXI_AWREADY,
  input wire [31:0]   S_AXI_WDATA,
  input wire [3:0]    S_AXI_WSTRB,
  input wire          S_AXI_WVALID,
  input wire [AW-1:0] S_AXI_ARADDR,
  input wire          S_AXI_ARVALID,
  input wire          S_AXI_ARREADY,
  input wire [31:0]   S_AXI_RDATA,
  input wire          RESULT_READY_N,
  input wire          FILTER_RESET,
  input wire          SHORT_INPUTS,
  input wire          CHANNEL,
  input wire          POWER_DOWN
);
  reg [15:0] high_cnt_reg;
  reg        ch_reg;
  reg        pd_reg;
  reg        rd_seen_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_comm_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_AWADDR == 0 && S_AXI_WSTRB[0];
  endsequence
  sequence s_comm_rd;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 0;
  endsequence
  // Counts how long the ready output has stood high, and keeps the last control word.
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      high_cnt_reg <= 16'h0000;
      ch_reg       <= 1'b0;
      pd_reg       <= 1'b0;
      rd_seen_reg  <= 1'b0;
    end else begin
      high_cnt_reg <= !RESULT_READY_N ? 16'h0000 : high_cnt_reg + {15'h0000, ~&high_cnt_reg};
      // A data read may raise ready just before a new result; only unread gaps are timed.
      if (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h0C)
        rd_seen_reg <= 1'b1;
      else if (!RESULT_READY_N)
        rd_seen_reg <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_AWADDR == 0) begin
        ch_reg <= S_AXI_WSTRB[0] ? S_AXI_WDATA[0] : ch_reg;
        pd_reg <= S_AXI_WSTRB[0] ? S_AXI_WDATA[2] : pd_reg;
      end
    end
  end
  a_comm_fields: assert property (s_comm_wr |=> ##[0:1]
    (CHANNEL == ch_reg && POWER_DOWN == pd_reg)) else $error("control word not applied");
  a_hold_freeze: assert property (FILTER_RESET && $past(FILTER_RESET) && RESULT_READY_N
    |=> RESULT_READY_N) else $error("result appeared under hold");
  a_fall_conv: assert property ($fell(RESULT_READY_N) |->
    !$past(FILTER_RESET) && !SHORT_INPUTS) else $error("result outside conversion");
  a_blip_len: assert property ($fell(RESULT_READY_N) && !rd_seen_reg |->
    high_cnt_reg >= BLIP_CYC) else $error("overrun gap too short");
  a_comm_status: assert property (s_comm_rd |=>
    S_AXI_RDATA[7] == $past(RESULT_READY_N)) else $error("status bit differs from ready");
  a_short_end: assert property ($fell(SHORT_INPUTS) && !FILTER_RESET |->
    RESULT_READY_N [*8]) else $error("ready low right after zero step");
  a_short_busy: assert property (SHORT_INPUTS && $past(SHORT_INPUTS) |->
    RESULT_READY_N) else $error("ready low while inputs shorted");
  a_start_raise: assert property ($fell(FILTER_RESET) |->
    ##[0:128] RESULT_READY_N) else $error("ready not raised at start");
endmodule
bind acs_sequencer acs_sequencer_chk #(.AW(AW), .BLIP_CYC(BLIP_CYC)) acs_sequencer_chk_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .RESULT_READY_N(RESULT_READY_N),
  .FILTER_RESET(FILTER_RESET), .SHORT_INPUTS(SHORT_INPUTS), .CHANNEL(CHANNEL),
  .POWER_DOWN(POWER_DOWN));

//--- acs_filter_model.sv
// Behavioural filter and coefficient arithmetic beside the sequencer.
// Assumes the sequencer samples these lines on the same clock.
`timescale 1ns/1ps
module acs_filter_model (
  input  wire        clk,
  input  wire        rst,
  input  wire        filter_reset,
  input  wire        channel,
  output wire [15:0] sample,
  output wire [23:0] offset,
  output wire [23:0] gain
);
  reg [15:0] tick_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end
  // The sample moves every cycle, so a held result is told apart from a live one.
  assign sample = tick_reg ^ 16'h5A5A;
  // Each channel gets its own coefficients; in filter reset the lines carry junk.
  assign offset = filter_reset ? {8'hFF, tick_reg} : {7'h18, channel, 16'h5A5A};
  assign gain   = filter_reset ? {tick_reg, 8'h00} : {7'h30, channel, 16'hA5A5};
endmodule

//--- tb_acs_sequencer.sv
// Self-checking bench of the ADC sequencer: bus tasks and one task per scenario.
// Assumes the filter model beside the sequencer and the bound checker.
`timescale 1ns/1ps
`include "acs_regs.vh"
module tb_acs_sequencer;
  localparam int P = 4864;
  localparam int T = 100;
  localparam int B = 40;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg         ch = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, rdy_n, frst, shrt, chan, pdn;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] smp;
  wire [23:0] ofs, gn;
  int         cyc = 0;
  int         t0 = 0;
  int         t_last = 0;
  int         n_errors = 0;
  int         compares = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  acs_sequencer #(.PIPE_CYC(T), .BLIP_CYC(B)) acs_sequencer_inst (.CLK(clk), .SYS_RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .SAMPLE_IN(smp), .CAL_OFFSET_IN(ofs), .CAL_GAIN_IN(gn),
    .RESULT_READY_N(rdy_n), .FILTER_RESET(frst), .SHORT_INPUTS(shrt), .CHANNEL(chan),
    .POWER_DOWN(pdn));
  acs_filter_model acs_filter_model_inst (.clk(clk), .rst(rst), .filter_reset(frst),
    .channel(chan), .sample(smp), .offset(ofs), .gain(gn));
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
    end while (awready !== 1'b1 || wready !== 1'b1);
    t_last = cyc;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic axr(input [7:0] a, output [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", 2'h0, rresp);
  endtask
  task automatic wreg(input [2:0] i, input [31:0] d);
    axw(8'h00, {25'h0, i, 3'h0, ch}, 2'h0);
    axw({3'h0, i, 2'h0}, d, 2'h0);
    t0 = t_last;
  endtask
  task automatic rreg(input [2:0] i, output [31:0] d);
    axw(8'h00, {25'h0, i, 3'h4, ch}, 2'h0);
    axr({3'h0, i, 2'h0}, d);
  endtask
  task automatic wait_rdy(input logic lvl, input int e, input int tol, input string nm);
    int g;
    while (rdy_n !== lvl && cyc - t0 < e + tol)
      @(posedge clk);
    g = (rdy_n !== lvl) ? -1 : cyc - t0;
    if (g >= e - tol && g <= e + tol) g = e;
    chk(nm, e, g);
  endtask
  task automatic wait_to(input int c);
    while (cyc - t0 < c)
      @(posedge clk);
  endtask
  task automatic t_start;
    reg [31:0] d;
    chk("filter reset", 1, frst);
    axw(8'h04, 32'h0, 2'h0);
    axw(8'h40, 32'h0, 2'h2);
    axw(8'h00, 32'h05, 2'h0);
    chk("power down", 1, pdn);
    chk("channel", 1, chan);
    rreg(`ACS_IDX_SETUP, d);
    chk("setup", 32'h01, d);
    chk("power up", 0, pdn);
    axr(8'h04, d);
    chk("unarmed", 32'h0, d);
    wreg(`ACS_IDX_CLOCK, 32'h07);
    rreg(`ACS_IDX_CLOCK, d);
    chk("clock", 32'h07, d);
    wreg(`ACS_IDX_SETUP, 32'hC1);
    rreg(`ACS_IDX_SETUP, d);
    chk("mode", 32'hC1, d);
    chk("held", 1, rdy_n);
  endtask
  task automatic t_normal;
    reg [31:0] d1, d2;
    wreg(`ACS_IDX_SETUP, 32'h00);
    wait_rdy(0, 3 * P + 3, 3, "first");
    t0 = cyc;
    axr(8'h00, d1);
    chk("status", 0, d1[7]);
    rreg(`ACS_IDX_DATA, d1);
    // The model's sample counts edges from reset release, so this result holds t0 - 21.
    chk("data", {16'h0000, 16'(t0 - 21) ^ 16'h5A5A}, d1);
    repeat (2) @(posedge clk);
    chk("read raise", 1, rdy_n);
    rreg(`ACS_IDX_DATA, d2);
    chk("reread", d1, d2);
    wait_rdy(0, P, 3, "period");
    t0 = cyc;
    wait_rdy(1, P, 3, "overrun");
    t0 = cyc;
    wait_rdy(0, B, 2, "gap");
    wreg(`ACS_IDX_SETUP, 32'h01);
    repeat (40) @(posedge clk);
    chk("hold low", 0, rdy_n);
    chk("hold filter", 1, frst);
    rreg(`ACS_IDX_DATA, d1);
    repeat (2) @(posedge clk);
    chk("read raise", 1, rdy_n);
  endtask
  task automatic t_cal(input [7:0] m, input [2:0] oi, input [2:0] gi, input int n, input int r);
    reg [31:0] d;
    wreg(`ACS_IDX_SETUP, {24'h0, m} | 32'h01);
    chk("frozen", ch ? 1 : 0, rdy_n);
    wreg(`ACS_IDX_SETUP, {24'h0, m});
    wait_rdy(1, 64, 64, "raise");
    wait_to(2 * P);
    chk("short", m == 8'h40, shrt);
    wait_to(n * P - 40);
    rreg(`ACS_IDX_SETUP, d);
    chk("mode busy", m, d);
    wait_to(n * P + 40);
    rreg(`ACS_IDX_SETUP, d);
    chk("mode done", 32'h00, d);
    chk("short off", 0, shrt);
    wait_rdy(0, r * P + T + 3, 3, "cal result");
    rreg(oi, d);
    chk("offset", {7'h18, ch, 16'h5A5A}, d);
    rreg(gi, d);
    chk("gain", m == 8'h80 ? 24'h0 : {7'h30, ch, 16'hA5A5}, d);
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_start;
    t_normal;
    ch = 1'b1;
    t_cal(8'h40, `ACS_IDX_OFS1, `ACS_IDX_GAIN1, 6, 9);
    ch = 1'b0;
    t_cal(8'h80, `ACS_IDX_OFS0, `ACS_IDX_GAIN0, 3, 4);
    close_out;
  end
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule
